/* src/dpcm_regs.vh */
`ifndef DPCM_REGS_VH
`define DPCM_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define DPCM_OFS_FLAGS      4'h0
`define DPCM_OFS_DROOP      4'h4
`define DPCM_OFS_STATUS     4'h8

// ----------------------------------------------------------------------
// Power management flags word fields
// ----------------------------------------------------------------------
`define DPCM_FLG_TH_LSB     4
`define DPCM_FLG_TH_MSB     5
`define DPCM_FLG_SEL        6
`define DPCM_FLG_EN         8

// ----------------------------------------------------------------------
// Droop gain word fields and codes
// ----------------------------------------------------------------------
`define DPCM_DRP_LSB        0
`define DPCM_DRP_MSB        1
`define DPCM_DRP_QUARTER    2'h0
`define DPCM_DRP_HALF       2'h1
`define DPCM_DRP_IGNORED    2'h2
`define DPCM_DRP_OFF        2'h3

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define DPCM_STS_WORK_LSB   0
`define DPCM_STS_WORK_MSB   2
`define DPCM_STS_STRAP_LSB  4
`define DPCM_STS_STRAP_MSB  6
`define DPCM_STS_ST_LSB     8
`define DPCM_STS_ST_MSB     11
`define DPCM_STS_PG         12

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DPCM_RST_TH         2'h0
`define DPCM_RST_SEL        1'b0
`define DPCM_RST_EN         1'b0
`define DPCM_RST_DRP        2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DPCM_CLK_NS         20
`define DPCM_REEN_NS        20000
`define DPCM_REEN_CYC       (`DPCM_REEN_NS / `DPCM_CLK_NS)
`define DPCM_STRAP_CYC      3'h4

`endif

/* src/dpcm_sync.v */
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bundle of independent levels
module dpcm_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

/* src/dpcm_top.v */
// Behaviour
// - Enabled and sense below falling threshold: drop to light-load phase count.
// - Sense above rising threshold: restore strapped phase count at once.
// - Threshold code 00..11 selects rising level 20/25/30/35 percent, default 00.
// - Falling level sits five points below rising level for hysteresis.
// - Dropping off after reset; start-up runs with every available phase.
// - Enable command only taken once power-good is high after start-up.
// - While enabled, sense comparison continuously decides working phase count.
// - Voltage transition in progress forces full count and resets dropping.
// - Load-step report forces full count and resets dropping.
// - After a reset, wait a delay, then rechoose count from comparison.
// - Strap: third and fourth grounded 2, fourth only 3, none 4.
// - Current-sharing divisor equals number of working phases.
// - Droop gain setting held in a register, reset default one quarter.
// - Light-load select 0 gives single phase, 1 gives two phases.
// - Flags word: threshold code bits 5:4, select bit 6, enable bit 8.
`include "dpcm_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dpcm_top
#(
   parameter REEN_CYC = `DPCM_REEN_CYC,
   parameter NPH      = 4
)
(
   input  wire            clk_i,
   input  wire            rst_i,
   // Classic Wishbone slave
   input  wire            wb_cyc_i,
   input  wire            wb_stb_i,
   input  wire            wb_we_i,
   input  wire [3:0]      wb_adr_i,
   input  wire [3:0]      wb_sel_i,
   input  wire [31:0]     wb_dat_i,
   output wire [31:0]     wb_dat_o,
   output wire            wb_ack_o,
   // Load-current comparator bank, bit k high: sense above (15+5k) percent
   input  wire [4:0]      load_current_sense_pin_cmp_i,
   input  wire            output_power_good_i,
   input  wire            on_the_fly_voltage_change_i,
   input  wire            load_transient_i,
   // Spare phase straps, high when the output is grounded
   input  wire            third_phase_output_gnd_i,
   input  wire            fourth_phase_output_gnd_i,
   // Power stage and current sharing
   output wire [NPH-1:0]  phase_enable_o,
   output wire [2:0]      average_phase_current_div_o,
   output wire [1:0]      core_droop_gain_o,
   output wire [1:0]      phase_drop_threshold_code_o
);

   // ----------------------------------------------------------------------
   // State codes
   // ----------------------------------------------------------------------
   localparam [3:0] ST_OFF  = 4'h1;
   localparam [3:0] ST_FULL = 4'h2;
   localparam [3:0] ST_DROP = 4'h4;
   localparam [3:0] ST_HOLD = 4'h8;

   localparam [15:0] REEN_LOAD = REEN_CYC[15:0];
   localparam [2:0]  STRAP_LOAD = `DPCM_STRAP_CYC;

   // ----------------------------------------------------------------------
   // Synchronised pin inputs
   // ----------------------------------------------------------------------
   wire [9:0] sync_w;
   wire [4:0] cmp_s;
   wire       pg_s;
   wire       otf_s;
   wire       step_s;
   wire       gnd3_s;
   wire       gnd4_s;

   // Comparators and all other pins share one synchroniser bank
   dpcm_sync
   #(
      .WIDTH (10)
   )
   u_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({fourth_phase_output_gnd_i, third_phase_output_gnd_i,
                 load_transient_i, on_the_fly_voltage_change_i,
                 output_power_good_i, load_current_sense_pin_cmp_i}),
      .sync_o  (sync_w)
   );

   assign cmp_s  = sync_w[4:0];
   assign pg_s   = sync_w[5];
   assign otf_s  = sync_w[6];
   assign step_s = sync_w[7];
   assign gnd3_s = sync_w[8];
   assign gnd4_s = sync_w[9];

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg  [1:0]     th_q;
   reg            sel_q;
   reg            en_q;
   reg  [1:0]     drp_q;
   reg  [3:0]     st_q;
   reg  [3:0]     st_d;
   reg  [15:0]    cnt_q;
   reg  [15:0]    cnt_d;
   reg  [2:0]     strap_q;
   reg  [2:0]     strap_cnt_q;
   reg            strap_ok_q;
   reg  [2:0]     work_q;
   reg  [2:0]     work_d;
   reg  [NPH-1:0] phen_q;
   reg  [31:0]    dat_q;
   reg            ack_q;

   wire       req_w;
   wire       wr_w;
   wire       above_rise_w;
   wire       below_fall_w;
   wire       force_w;
   wire [2:0] light_w;
   wire [2:0] strap_now_w;

   // ----------------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------------
   // Decode of the spare outputs; grounded third implies grounded fourth
   assign strap_now_w = gnd4_s ? (gnd3_s ? 3'h2 : 3'h3) : 3'h4;

   // Straps are caught a few cycles after release so the synchroniser has settled
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         strap_cnt_q <= STRAP_LOAD;
         strap_ok_q  <= 1'b0;
         strap_q     <= 3'h4;
      end
      else if (!strap_ok_q)
      begin
         if (strap_cnt_q == 3'h0)
         begin
            strap_q    <= strap_now_w;
            strap_ok_q <= 1'b1;
         end
         else
         begin
            strap_cnt_q <= strap_cnt_q - 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Threshold selection
   // ----------------------------------------------------------------------
   // Rising level is comparator th+1, falling level is comparator th
   assign above_rise_w = cmp_s[th_q + 2'h1 + 3'h0];
   assign below_fall_w = ~cmp_s[{1'b0, th_q}];
   assign light_w      = sel_q ? 3'h2 : 3'h1;
   assign force_w      = otf_s | step_s;

   // ----------------------------------------------------------------------
   // Phase count state machine
   // ----------------------------------------------------------------------
   // OFF: all phases; FULL/DROP: hysteresis loop; HOLD: forced full, timing out
   always @*
   begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      work_d = strap_q;
      case (st_q)
         ST_OFF:
         begin
            if (en_q && strap_ok_q)
            begin
               st_d = ST_FULL;
            end
         end
         ST_FULL:
         begin
            if (!en_q)
            begin
               st_d = ST_OFF;
            end
            else if (force_w)
            begin
               st_d  = ST_HOLD;
               cnt_d = REEN_LOAD;
            end
            else if (below_fall_w)
            begin
               st_d   = ST_DROP;
               work_d = light_w;
            end
         end
         ST_DROP:
         begin
            work_d = light_w;
            if (!en_q)
            begin
               st_d   = ST_OFF;
               work_d = strap_q;
            end
            else if (force_w)
            begin
               st_d   = ST_HOLD;
               cnt_d  = REEN_LOAD;
               work_d = strap_q;
            end
            else if (above_rise_w)
            begin
               st_d   = ST_FULL;
               work_d = strap_q;
            end
         end
         ST_HOLD:
         begin
            if (!en_q)
            begin
               st_d = ST_OFF;
            end
            else if (force_w)
            begin
               cnt_d = REEN_LOAD;
            end
            else if (cnt_q == 16'h0)
            begin
               if (below_fall_w)
               begin
                  st_d   = ST_DROP;
                  work_d = light_w;
               end
               else
               begin
                  st_d = ST_FULL;
               end
            end
            else
            begin
               cnt_d = cnt_q - 16'h1;
            end
         end
         default:
         begin
            st_d = ST_OFF;
         end
      endcase
   end

   // State, counter and working count
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q   <= ST_OFF;
         cnt_q  <= 16'h0;
         work_q <= 3'h4;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         work_q <= work_d;
      end
   end

   // ----------------------------------------------------------------------
   // Phase enables
   // ----------------------------------------------------------------------
   // One enable per phase, lit below the working count
   genvar gi;
   generate
      for (gi = 0; gi < NPH; gi = gi + 1)
      begin : g_phase
         localparam [31:0] IDX = gi;
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               phen_q[gi] <= 1'b1;
            end
            else
            begin
               phen_q[gi] <= (IDX < {29'h0, work_d});
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------------
   // Answer arrives one cycle after the request; ack drops the cycle after
   assign req_w = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_w  = req_w & wb_we_i;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end
      else
      begin
         ack_q <= req_w;
         if (req_w)
         begin
            case (wb_adr_i)
               `DPCM_OFS_FLAGS:
               begin
                  dat_q <= 32'h0;
                  dat_q[`DPCM_FLG_TH_MSB:`DPCM_FLG_TH_LSB] <= th_q;
                  dat_q[`DPCM_FLG_SEL] <= sel_q;
                  dat_q[`DPCM_FLG_EN]  <= en_q;
               end
               `DPCM_OFS_DROOP:
               begin
                  dat_q <= 32'h0;
                  dat_q[`DPCM_DRP_MSB:`DPCM_DRP_LSB] <= drp_q;
               end
               `DPCM_OFS_STATUS:
               begin
                  dat_q <= 32'h0;
                  dat_q[`DPCM_STS_WORK_MSB:`DPCM_STS_WORK_LSB]   <= work_q;
                  dat_q[`DPCM_STS_STRAP_MSB:`DPCM_STS_STRAP_LSB] <= strap_q;
                  dat_q[`DPCM_STS_ST_MSB:`DPCM_STS_ST_LSB]       <= st_q;
                  dat_q[`DPCM_STS_PG] <= pg_s;
               end
               default:
               begin
                  dat_q <= 32'h0;  // Unmapped reads as zero
               end
            endcase
         end
      end
   end

   // Flag and droop writes, honouring byte lanes 0 and 1
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         th_q  <= `DPCM_RST_TH;
         sel_q <= `DPCM_RST_SEL;
         en_q  <= `DPCM_RST_EN;
         drp_q <= `DPCM_RST_DRP;
      end
      else if (wr_w)
      begin
         if (wb_adr_i == `DPCM_OFS_FLAGS)
         begin
            if (wb_sel_i[0])
            begin
               th_q  <= wb_dat_i[`DPCM_FLG_TH_MSB:`DPCM_FLG_TH_LSB];
               sel_q <= wb_dat_i[`DPCM_FLG_SEL];
            end
            // Turning on before power-good is silently dropped; off is taken whenever byte lane 1 is selected
            if (wb_sel_i[1] && (!wb_dat_i[`DPCM_FLG_EN] || (pg_s && strap_ok_q)))
            begin
               en_q <= wb_dat_i[`DPCM_FLG_EN];
            end
         end
         if (wb_adr_i == `DPCM_OFS_DROOP && wb_sel_i[0])
         begin
            // The reserved code leaves the gain unchanged
            if (wb_dat_i[`DPCM_DRP_MSB:`DPCM_DRP_LSB] != `DPCM_DRP_IGNORED)
            begin
               drp_q <= wb_dat_i[`DPCM_DRP_MSB:`DPCM_DRP_LSB];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign wb_dat_o                     = dat_q;
   assign wb_ack_o                     = ack_q;
   assign phase_enable_o               = phen_q;
   assign average_phase_current_div_o  = work_q;
   assign core_droop_gain_o            = drp_q;
   assign phase_drop_threshold_code_o  = th_q;

endmodule

`default_nettype wire

/* sim/dpcm_load_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Load-current comparator front end
// ----------------------------------------
module dpcm_load_model
(
   input  wire logic [6:0] level_i,
   output logic      [4:0] cmp_o
);
   // Monotonic bank: bit k trips above (15+5k) percent, so a restore always implies no drop
   always_comb
      for (int k = 0; k < 5; k++)
         cmp_o[k] = (level_i > 7'(15 + 5 * k));
endmodule

`default_nettype wire

/* sim/dpcm_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module dpcm_chk
#(
   parameter REEN_CYC = 10
)
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic [4:0] load_current_sense_pin_cmp_i,
   input wire logic       on_the_fly_voltage_change_i,
   input wire logic       load_transient_i,
   input wire logic       third_phase_output_gnd_i,
   input wire logic       fourth_phase_output_gnd_i,
   input wire logic [3:0] phase_enable_o,
   input wire logic [2:0] average_phase_current_div_o,
   input wire logic [1:0] core_droop_gain_o,
   input wire logic [1:0] phase_drop_threshold_code_o
);
   logic [3:0] cnt_q;
   logic [2:0] strap_n;
   logic       ok_w;
   logic [2:0] dv;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Settle count: straps latch a few edges after reset, so the strap checks skip early cycles
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_q <= 4'h0;
      else if (cnt_q != 4'hf)
         cnt_q <= cnt_q + 4'h1;
   end
   assign ok_w = (cnt_q == 4'hf);
   assign dv = average_phase_current_div_o;
   assign strap_n = third_phase_output_gnd_i ? 3'h2 : (fourth_phase_output_gnd_i ? 3'h3 : 3'h4);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ack; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack is not a one-cycle answer");
   property p_enc; phase_enable_o == (4'hf >> (3'h4 - dv)); endproperty
   a_enc: assert property (p_enc) else $error("divisor and enables disagree");
   property p_rdiv; $fell(rst_i) |-> phase_enable_o == 4'hf && dv == 3'h4; endproperty
   a_rdiv: assert property (p_rdiv) else $error("not full count out of reset");
   property p_rdrp; $fell(rst_i) |-> core_droop_gain_o == 2'h0; endproperty
   a_rdrp: assert property (p_rdrp) else $error("droop gain not quarter at reset");
   property p_rcode; $fell(rst_i) |-> phase_drop_threshold_code_o == 2'h0; endproperty
   a_rcode: assert property (p_rcode) else $error("threshold code not 00 at reset");
   property p_otf; (ok_w && on_the_fly_voltage_change_i)[*5] |-> dv == strap_n; endproperty
   a_otf: assert property (p_otf) else $error("no full count in transition");
   property p_ltr; (ok_w && load_transient_i)[*5] |-> dv == strap_n; endproperty
   a_ltr: assert property (p_ltr) else $error("no full count on load step");
   property p_rest;
      (ok_w && load_current_sense_pin_cmp_i[phase_drop_threshold_code_o + 3'h1])[*5]
         |-> dv == strap_n;
   endproperty
   a_rest: assert property (p_rest) else $error("count not restored above rising");
   property p_reen;
      (ok_w && on_the_fly_voltage_change_i)[*5] ##1 !on_the_fly_voltage_change_i
         |=> (dv == strap_n)[*8];
   endproperty
   a_reen: assert property (p_reen) else $error("dropping resumed too early");
   property p_bound; ok_w |-> dv != 3'h0 && dv <= strap_n; endproperty
   a_bound: assert property (p_bound) else $error("count outside strapped range");

   c_one: cover property (dv == 3'h1);
   c_two: cover property (ok_w && dv == 3'h2 && strap_n == 3'h4);
   c_hold: cover property ((ok_w && load_transient_i)[*5]);
endmodule

bind dpcm_top dpcm_chk #(.REEN_CYC(REEN_CYC)) u_chk
(
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .load_current_sense_pin_cmp_i,
   .on_the_fly_voltage_change_i, .load_transient_i, .third_phase_output_gnd_i,
   .fourth_phase_output_gnd_i, .phase_enable_o, .average_phase_current_div_o,
   .core_droop_gain_o, .phase_drop_threshold_code_o
);

`default_nettype wire

/* sim/dpcm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dpcm_top_tb;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        pg_q, otf_q, ltr_q, g3_q, g4_q;
   logic [3:0]  wb_adr_i, wb_sel_i, pen_w;
   logic [31:0] wb_dat_i, wb_dat_o, rd_q, rng_q;
   logic [2:0]  div_w;
   logic [1:0]  drp_w, code_w;
   logic [4:0]  cmp_w;
   logic [6:0]  lvl_q;
   int          error_cnt, n_tests;

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Short re-enable delay keeps the hold scenarios brief
   dpcm_top #(.REEN_CYC(10)) dut_u
   (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .load_current_sense_pin_cmp_i(cmp_w),
      .output_power_good_i(pg_q), .on_the_fly_voltage_change_i(otf_q),
      .load_transient_i(ltr_q), .third_phase_output_gnd_i(g3_q),
      .fourth_phase_output_gnd_i(g4_q), .phase_enable_o(pen_w),
      .average_phase_current_div_o(div_w), .core_droop_gain_o(drp_w),
      .phase_drop_threshold_code_o(code_w)
   );
   dpcm_load_model load_u (.level_i(lvl_q), .cmp_o(cmp_w));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [3:0] mask(input logic [2:0] n);
      return 4'((5'h1 << n) - 5'h1);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic pick(input int lo, input int span);
      rng_q = xs(rng_q);
      lvl_q <= 7'(lo + int'(rng_q % span));
   endtask

   // Classic single cycle; waits for ack as long as it takes, then one idle cycle
   task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      @(posedge clk_i);
      // A slave that never answers is caught by the watchdog
      while (wb_ack_o !== 1'b1)
      begin
         @(posedge clk_i);
      end
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_ph(input logic [2:0] n);
      chk({29'h0, div_w}, {29'h0, n});
      chk({28'h0, pen_w}, {28'h0, mask(n)});
   endtask

   task automatic do_reset(input logic a, input logic b);
      rst_i <= 1'b1;
      g3_q <= a;
      g4_q <= b;
      tick(6);
      rst_i <= 1'b0;
      tick(12);
   endtask

   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [1:0] e;
      int         c;
      int         l;
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pg_q, otf_q, ltr_q, g3_q, g4_q} = 9'h100;
      {wb_adr_i, wb_sel_i, wb_dat_i, lvl_q} = '0;
      rng_q = 32'h61d2;
      error_cnt = 0;
      n_tests = 0;
      @(posedge clk_i);
      for (int s = 0; s < 3; s++)
      begin
         do_reset(s < 1, s < 2);
         chk_ph(3'(2 + s));
      end
      bus(1'b0, 4'h0, 32'h0);
      chk(rd_q, 32'h0);
      // Host breaks the order on purpose: enable before power-good is refused
      bus(1'b1, 4'h0, 32'h100);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd_q, 32'h0);
      tick(8);
      chk_ph(3'h4);
      pg_q <= 1'b1;
      tick(4);
      e = 2'h0;
      for (int d = 1; d < 5; d++)
      begin
         if (d % 4 != 2)
            e = 2'(d % 4);
         bus(1'b1, 4'h4, 32'(d % 4));
         bus(1'b0, 4'h4, 32'h0);
         chk(rd_q, {30'h0, e});
         chk({30'h0, drp_w}, {30'h0, e});
      end
      rng_q = xs(rng_q);
      bus(1'b1, 4'hc, rng_q);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd_q, 32'h0);
      // Every code under both light-load choices, with the hysteresis band probed
      for (int i = 0; i < 8; i++)
      begin
         c = i % 4;
         l = i / 4;
         bus(1'b1, 4'h0, 32'h100 + 32'(l * 64 + c * 16));
         chk({30'h0, code_w}, 32'(c));
         pick(0, 16 + 5 * c);
         tick(8);
         chk_ph(3'(l + 1));
         bus(1'b0, 4'h8, 32'h0);
         chk(rd_q & 32'h1077, 32'h1040 + 32'(l + 1));
         pick(16 + 5 * c, 5);
         tick(8);
         chk_ph(3'(l + 1));
         pick(21 + 5 * c, 20);
         tick(8);
         chk_ph(3'h4);
         pick(16 + 5 * c, 5);
         tick(8);
         chk_ph(3'h4);
      end
      bus(1'b1, 4'h0, 32'h100);
      for (int k = 0; k < 2; k++)
      begin
         pick(0, 16);
         tick(8);
         chk_ph(3'h1);
         if (k == 0)
            otf_q <= 1'b1;
         else
            ltr_q <= 1'b1;
         tick(6);
         chk_ph(3'h4);
         otf_q <= 1'b0;
         ltr_q <= 1'b0;
         tick(6);
         chk_ph(3'h4);
         tick(12);
         chk_ph(3'h1);
      end
      bus(1'b1, 4'h0, 32'h0);
      tick(8);
      chk_ph(3'h4);
      summarize();
   end

   // Whole run is under a thousand cycles; ten times that means a hang
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule

`default_nettype wire
